/* src/bth_pkg.sv */
/*
 * Package for the bus terminal host control block: register selects, config and mask
 * field positions, block status word layout, stack geometry and timing counts.
 * Assumes a 20 MHz system clock.
 */
package bth_pkg;
	localparam int CLK_MHZ = 20;
	// register select codes (addr bits 2..0)
	localparam logic [2:0] REG_MASK = 3'h0;
	localparam logic [2:0] REG_CFG = 3'h1;
	localparam logic [2:0] REG_CMD = 3'h3;
	// configuration field positions
	localparam int CFG_AREA = 13;
	localparam int CFG_MODE_LO = 14;
	localparam int CFG_MODE_HI = 15;
	localparam int CFG_STOP_ERR = 4;
	localparam int CFG_FLAG_LO = 0;
	localparam int CFG_FLAG_HI = 3;
	// command bits
	localparam int CMD_START = 0;
	localparam int CMD_RESET = 1;
	// interrupt mask bits
	localparam int MSK_EOM = 0;
	localparam int MSK_FMT_STAT = 1;
	localparam int MSK_BLOCK_END = 2;
	// block status word bits
	localparam int BSW_EOM = 15;
	localparam int BSW_SOM = 14;
	localparam int BSW_CHAN = 13;
	localparam int BSW_ERR = 12;
	localparam int BSW_STAT_SET = 11;
	localparam int BSW_FORMAT = 10;
	localparam int BSW_TIMEOUT = 9;
	localparam int BSW_LOOP = 8;
	localparam logic [15:0] ZERO16 = 16'h0000;
	// stack geometry
	localparam int STACK_ENTRIES = 64;
	localparam int ENTRY_WORDS = 4;
	localparam logic [7:0] PTR_STEP = 8'h04;
	// response timeout
	localparam int RESP_TIMEOUT_US = 14;
	localparam int RESP_TIMEOUT_CYC = RESP_TIMEOUT_US * CLK_MHZ;
	typedef enum logic [1:0] {
		MODE_BC = 2'b00,
		MODE_RT = 2'b10,
		MODE_MON = 2'b01,
		MODE_BAD = 2'b11
	} bth_mode_t;
	// message events from protocol logic
	typedef struct packed {
		logic start;
		logic done;
		logic bus_b;
		logic par_err;
		logic manch_err;
		logic sync_err;
		logic cnt_err;
		logic gap_err;
		logic addr_err;
		logic loop_fail;
		logic stat_flag;
		logic no_resp;
		logic block_end;
	} bth_msg_t;
	// descriptor stack write request
	typedef struct packed {
		logic we;
		logic [15:0] addr;
		logic [15:0] data;
	} bth_mem_t;
endpackage : bth_pkg

/* src/bth_host_ctrl.sv */
/*
 * Host control block of a dual-redundant bus terminal: internal registers, external
 * register strobes, current area swap, descriptor stack bookkeeping, block status word.
 * Assumes host pins arrive asynchronous; protocol events are on clk_i.
 */
module bth_host_ctrl
	import bth_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic sel_n_i,
	input wire logic memreg_n_i,
	input wire logic wr_n_i,
	input wire logic [2:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire bth_pkg::bth_msg_t msg_i,
	input wire logic [15:0] time_tag_i,
	input wire logic [15:0] cmd_word_i,
	input wire logic [15:0] blk_addr_i,
	input wire logic [7:0] sp_hi_a_i,
	input wire logic [7:0] sp_hi_b_i,
	output logic [15:0] rdata_o,
	output logic ext_register_output_enable_n_o,
	output logic ext_register_load_strobe_n_o,
	output logic int_n_o,
	output logic area_b_o,
	output bth_pkg::bth_mode_t mode_o,
	output logic run_o,
	output logic [3:0] status_flags_o,
	output logic [15:0] lut_index_o,
	output bth_pkg::bth_mem_t mem_o
);
	import bth_pkg::*;

	// host strobe synchronisers: three stages, change counts when 2 and 3 agree
	logic [2:0] sel_s_q, sel_s_d;
	logic sel_q, sel_d;
	logic [15:0] mask_q, mask_d, cfg_q, cfg_d;
	logic area_q, area_d, busy_q, busy_d, run_q, run_d;
	logic [7:0] sp_lo_a_q, sp_lo_a_d, sp_lo_b_q, sp_lo_b_d;
	logic [15:0] bsw_q, bsw_d;
	logic [1:0] wcnt_q, wcnt_d;
	logic [15:0] rdata_q, rdata_d;
	logic ext_register_output_enable_n_q, ext_register_output_enable_n_d, ext_register_load_strobe_n_q, ext_register_load_strobe_n_d, int_n_q, int_n_d;
	bth_mem_t mem_q, mem_d;
	logic [15:0] lut_q, lut_d;
	logic [8:0] tmo_q, tmo_d;
	logic tmo_flag_q, tmo_flag_d;

	logic acc, is_wr, soft_rst, any_err, fmt_err;

	function automatic logic [15:0] entry_addr(input logic [7:0] hi, input logic [7:0] lo, input logic [1:0] w);
		entry_addr = {hi, lo + 8'(w)};
	endfunction

	assign sel_d = sel_s_q[1] & sel_s_q[2] ? 1'b1 : (~sel_s_q[1] & ~sel_s_q[2] ? 1'b0 : sel_q);
	assign acc = sel_d & ~sel_q & ~memreg_n_i;
	assign is_wr = ~wr_n_i;
	assign soft_rst = acc & is_wr & (addr_i == REG_CMD) & wdata_i[CMD_RESET];
	assign fmt_err = msg_i.par_err | msg_i.manch_err | msg_i.sync_err | msg_i.cnt_err
		| msg_i.gap_err | (mode_o == MODE_RT && msg_i.addr_err);
	assign any_err = fmt_err | msg_i.loop_fail | tmo_flag_q | msg_i.no_resp
		| (mode_o == MODE_BC && (msg_i.stat_flag | msg_i.addr_err));

	always_comb begin
		sel_s_d = {sel_s_q[1:0], ~sel_n_i};
		mask_d = mask_q;
		cfg_d = cfg_q;
		area_d = area_q;
		busy_d = busy_q;
		run_d = run_q;
		sp_lo_a_d = sp_lo_a_q;
		sp_lo_b_d = sp_lo_b_q;
		bsw_d = bsw_q;
		wcnt_d = wcnt_q;
		rdata_d = rdata_q;
		ext_register_output_enable_n_d = 1'b1;
		ext_register_load_strobe_n_d = 1'b1;
		int_n_d = 1'b1;
		mem_d = '0;
		lut_d = lut_q;
		tmo_d = tmo_q;
		tmo_flag_d = tmo_flag_q;
		if (acc) begin
			if (addr_i[2]) begin
				ext_register_output_enable_n_d = ~wr_n_i;
				ext_register_load_strobe_n_d = wr_n_i;
			end else if (is_wr) begin
				case (addr_i)
					REG_MASK: mask_d = wdata_i;
					REG_CFG: cfg_d = (wdata_i[CFG_MODE_HI:CFG_MODE_LO] == 2'b11) ? cfg_q : wdata_i;
					REG_CMD: if (wdata_i[CMD_START]) run_d = 1'b1;
					default: ;
				endcase
			end else begin
				case (addr_i)
					REG_MASK: rdata_d = mask_q;
					REG_CFG: rdata_d = cfg_q;
					default: rdata_d = ZERO16;
				endcase
			end
		end
		// the swap also waits out the end-of-message writes, which still address the old area
		if (!busy_q && wcnt_q == 2'h0) area_d = cfg_q[CFG_AREA];
		// controller response timer
		if (busy_q && mode_o == MODE_BC) begin
			if (tmo_q == 9'(RESP_TIMEOUT_CYC)) tmo_flag_d = 1'b1;
			else tmo_d = tmo_q + 9'h001;
		end
		if (msg_i.start && !busy_q) begin
			busy_d = 1'b1;
			tmo_d = '0;
			tmo_flag_d = 1'b0;
			bsw_d = ZERO16;
			bsw_d[BSW_SOM] = 1'b1;
			mem_d = '{we: 1'b1, addr: entry_addr(area_q ? sp_hi_b_i : sp_hi_a_i,
				area_q ? sp_lo_b_q : sp_lo_a_q, 2'h1), data: time_tag_i};
			lut_d = {6'h00, cmd_word_i[10], cmd_word_i[9:5], 4'h0};
		end else if (msg_i.done && busy_q) begin
			busy_d = 1'b0;
			bsw_d[BSW_SOM] = 1'b0;
			bsw_d[BSW_EOM] = 1'b1;
			bsw_d[BSW_CHAN] = msg_i.bus_b;
			bsw_d[BSW_ERR] = any_err;
			bsw_d[BSW_STAT_SET] = mode_o == MODE_BC && (msg_i.stat_flag | msg_i.addr_err);
			bsw_d[BSW_FORMAT] = fmt_err;
			bsw_d[BSW_TIMEOUT] = tmo_flag_q | msg_i.no_resp;
			bsw_d[BSW_LOOP] = msg_i.loop_fail;
			wcnt_d = 2'h1;
			if ((mask_q[MSK_EOM]) || (mask_q[MSK_FMT_STAT] && any_err)
				|| (mask_q[MSK_BLOCK_END] && msg_i.block_end && mode_o == MODE_BC))
				int_n_d = 1'b0;
			if ((cfg_q[CFG_STOP_ERR] && any_err && mode_o == MODE_BC) || msg_i.block_end)
				run_d = 1'b0;
		end else if (wcnt_q != 2'h0) begin
			// end-of-message writes: status, tag update, fourth word, then advance
			case (wcnt_q)
				2'h1: mem_d = '{we: 1'b1, addr: entry_addr(area_q ? sp_hi_b_i : sp_hi_a_i,
					area_q ? sp_lo_b_q : sp_lo_a_q, 2'h0), data: bsw_q};
				2'h2: mem_d = '{we: 1'b1, addr: entry_addr(area_q ? sp_hi_b_i : sp_hi_a_i,
					area_q ? sp_lo_b_q : sp_lo_a_q, 2'h1), data: time_tag_i};
				default: mem_d = '{we: 1'b1, addr: entry_addr(area_q ? sp_hi_b_i : sp_hi_a_i,
					area_q ? sp_lo_b_q : sp_lo_a_q, 2'h3),
					data: (mode_o == MODE_BC) ? blk_addr_i : cmd_word_i};
			endcase
			if (wcnt_q == 2'h3) begin
				if (area_q) sp_lo_b_d = sp_lo_b_q + PTR_STEP;
				else sp_lo_a_d = sp_lo_a_q + PTR_STEP;
			end
			wcnt_d = wcnt_q + 2'h1;
		end
		if (soft_rst) begin
			mask_d = ZERO16;
			cfg_d = ZERO16;
			bsw_d = ZERO16;
			busy_d = 1'b0;
			run_d = 1'b0;
			wcnt_d = 2'h0;
			mem_d = '0;
			int_n_d = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sel_s_q <= 3'h0;
			sel_q <= 1'b0;
			mask_q <= ZERO16;
			cfg_q <= ZERO16;
			area_q <= 1'b0;
			busy_q <= 1'b0;
			run_q <= 1'b0;
			sp_lo_a_q <= 8'h00;
			sp_lo_b_q <= 8'h00;
			bsw_q <= ZERO16;
			wcnt_q <= 2'h0;
			rdata_q <= ZERO16;
			ext_register_output_enable_n_q <= 1'b1;
			ext_register_load_strobe_n_q <= 1'b1;
			int_n_q <= 1'b1;
			mem_q <= '0;
			lut_q <= ZERO16;
			tmo_q <= 9'h000;
			tmo_flag_q <= 1'b0;
		end else begin
			sel_s_q <= sel_s_d;
			sel_q <= sel_d;
			mask_q <= mask_d;
			cfg_q <= cfg_d;
			area_q <= area_d;
			busy_q <= busy_d;
			run_q <= run_d;
			sp_lo_a_q <= sp_lo_a_d;
			sp_lo_b_q <= sp_lo_b_d;
			bsw_q <= bsw_d;
			wcnt_q <= wcnt_d;
			rdata_q <= rdata_d;
			ext_register_output_enable_n_q <= ext_register_output_enable_n_d;
			ext_register_load_strobe_n_q <= ext_register_load_strobe_n_d;
			int_n_q <= int_n_d;
			mem_q <= mem_d;
			lut_q <= lut_d;
			tmo_q <= tmo_d;
			tmo_flag_q <= tmo_flag_d;
		end
	end

	assign rdata_o = rdata_q;
	assign ext_register_output_enable_n_o = ext_register_output_enable_n_q;
	assign ext_register_load_strobe_n_o = ext_register_load_strobe_n_q;
	assign int_n_o = int_n_q;
	assign area_b_o = area_q;
	assign mode_o = bth_mode_t'(cfg_q[CFG_MODE_HI:CFG_MODE_LO]);
	assign run_o = run_q;
	assign status_flags_o = ~cfg_q[CFG_FLAG_HI:CFG_FLAG_LO];
	assign lut_index_o = lut_q;
	assign mem_o = mem_q;

	a_area_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		busy_q && $past(busy_q) |-> area_q == $past(area_q)) else $error("area changed mid message");
	a_som_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		msg_i.start && !busy_q && !soft_rst |=> bsw_q[BSW_SOM] && !bsw_q[BSW_EOM]) else $error("start flag");
	a_eom_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		msg_i.done && busy_q && !soft_rst |=> bsw_q[BSW_EOM] && !bsw_q[BSW_SOM]) else $error("end flag");
	a_err_sum: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$rose(bsw_q[BSW_FORMAT]) |-> bsw_q[BSW_ERR]) else $error("error summary missing");
	a_tag_start: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		msg_i.start && !busy_q && !soft_rst |=> mem_o.we && mem_o.data == $past(time_tag_i)) else $error("tag");
	a_int_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!int_n_o |=> int_n_o) else $error("interrupt not a pulse");
	a_int_eom: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		msg_i.done && busy_q && mask_q[MSK_EOM] && !soft_rst |=> !int_n_o) else $error("missing interrupt");
	a_reset_cfg: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		soft_rst |=> cfg_q == ZERO16 && mask_q == ZERO16 && !busy_q) else $error("soft reset");
	a_mode_legal: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		mode_o != MODE_BAD) else $error("illegal mode");
	a_flag_inv: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		status_flags_o == ~cfg_q[CFG_FLAG_HI:CFG_FLAG_LO]) else $error("flag polarity");
	c_msg: cover property (@(posedge clk_i) disable iff (!rst_n_i) msg_i.start ##[1:400] msg_i.done);
	c_swap: cover property (@(posedge clk_i) disable iff (!rst_n_i) $changed(area_q));
	c_timeout: cover property (@(posedge clk_i) disable iff (!rst_n_i) $rose(tmo_flag_q));
endmodule // bth_host_ctrl

/* bench/bth_host_model.sv */
/*
 * Host processor model: register cycles on the select/address/data pins.
 * Assumes the block takes a request a few clocks after select falls.
 */
module bth_host_model (
	input wire logic clk_i,
	input wire logic [15:0] rdata_i,
	input wire logic oe_n_i,
	input wire logic ld_n_i,
	output logic sel_n_o,
	output logic memreg_n_o,
	output logic wr_n_o,
	output logic [2:0] addr_o,
	output logic [15:0] wdata_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		sel_n_o = 1'b1;
		memreg_n_o = 1'b1;
		wr_n_o = 1'b1;
		addr_o = 3'h0;
		wdata_o = 16'h0000;
	end
	task automatic access(input logic w, input logic [2:0] a, input logic [15:0] d, output logic [15:0] rd,
		output int oe, output int ld);
		@(negedge clk_i);
		sel_n_o = 1'b0;
		memreg_n_o = 1'b0;
		wr_n_o = ~w;
		addr_o = a;
		wdata_o = d;
		oe = 0;
		ld = 0;
		repeat (6) begin
			@(negedge clk_i);
			oe += (oe_n_i === 1'b0);
			ld += (ld_n_i === 1'b0);
		end
		rd = rdata_i;
		sel_n_o = 1'b1;
		memreg_n_o = 1'b1;
		wr_n_o = 1'b1;
		// released pins show the inverse so a stale value is never mistaken for a hold
		addr_o = ~a;
		wdata_o = ~d;
		repeat (4) @(negedge clk_i);
	endtask
endmodule // bth_host_model

/* bench/test_bus_terminal_host_control.sv */
/*
 * Self-checking bench for the host control block: register cycles through the host model,
 * message events driven directly. Assumes a 20 MHz clock and the package constants.
 */
module test_bus_terminal_host_control;
	timeunit 1ns;
	timeprecision 1ns;
	import bth_pkg::*;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic sel_n, memreg_n, wr_n, area_b, run, oe_n, ld_n, int_n;
	logic [2:0] addr;
	logic [15:0] wdata, rdata, lut, rd;
	logic [15:0] tag = 16'h0000;
	logic [15:0] cmdw = 16'h0420;
	logic [15:0] blka = 16'h0ABC;
	logic [3:0] flags;
	logic [7:0] ptr = 8'h00;
	bth_msg_t m = '0;
	bth_msg_t ev;
	bth_mode_t mode;
	bth_mem_t mem;
	bth_mem_t q[$];
	int failures = 0;
	int comparisons = 0;
	int isn, oe, ld;
	initial forever #25 clk_i = ~clk_i;
	bth_host_model u_host (.clk_i(clk_i), .rdata_i(rdata), .oe_n_i(oe_n), .ld_n_i(ld_n), .sel_n_o(sel_n),
		.memreg_n_o(memreg_n), .wr_n_o(wr_n), .addr_o(addr), .wdata_o(wdata));
	bth_host_ctrl u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .sel_n_i(sel_n), .memreg_n_i(memreg_n),
		.wr_n_i(wr_n), .addr_i(addr), .wdata_i(wdata), .msg_i(m), .time_tag_i(tag), .cmd_word_i(cmdw),
		.blk_addr_i(blka), .sp_hi_a_i(8'h12), .sp_hi_b_i(8'h12), .rdata_o(rdata),
		.ext_register_output_enable_n_o(oe_n), .ext_register_load_strobe_n_o(ld_n), .int_n_o(int_n),
		.area_b_o(area_b), .mode_o(mode), .run_o(run), .status_flags_o(flags), .lut_index_o(lut),
		.mem_o(mem));
	always @(negedge clk_i) begin
		if (mem.we === 1'b1)
			q.push_back(mem);
		if (int_n === 1'b0)
			isn++;
	end
	task automatic summarize();
		if (failures == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		u_host.access(1'b1, a, d, rd, oe, ld);
	endtask
	task automatic rdchk(input string n, input logic [2:0] a, input logic [15:0] e);
		u_host.access(1'b0, a, 16'h0000, rd, oe, ld);
		chk(n, e, rd);
	endtask
	// one message: start, optional area swap in flight, done with the given error events
	task automatic msg(input bth_msg_t e, input logic [15:0] block_status_word, input int xint, input logic [15:0] w4,
		input logic swap);
		q.delete();
		isn = 0;
		@(negedge clk_i);
		tag = 16'h1111;
		m = '0;
		m.start = 1'b1;
		@(negedge clk_i);
		m = '0;
		if (swap) begin
			wr(REG_CFG, 16'h8000);
			chk("area_held", 16'h0001, {15'h0, area_b});
		end
		repeat (3) @(negedge clk_i);
		tag = 16'h2222;
		m = e;
		m.done = 1'b1;
		@(negedge clk_i);
		m = '0;
		repeat (8) @(negedge clk_i);
		if (swap)
			chk("area_swapped", 16'h0000, {15'h0, area_b});
		chk("int_pulses", 16'(xint), 16'(isn));
		chk("writes", 16'h0004, 16'(q.size()));
		if (q.size() == 4) begin
			chk("tag0_addr", {8'h12, ptr + 8'h01}, q[0].addr);
			chk("tag0", 16'h1111, q[0].data);
			chk("bsw_addr", {8'h12, ptr}, q[1].addr);
			chk("bsw", block_status_word, q[1].data);
			chk("tag1_addr", {8'h12, ptr + 8'h01}, q[2].addr);
			chk("tag1", 16'h2222, q[2].data);
			chk("w4_addr", {8'h12, ptr + 8'h03}, q[3].addr);
			chk("w4", w4, q[3].data);
		end
		// after a swap the next entry goes to area A, whose pointer has not moved yet
		ptr = swap ? 8'h00 : ptr + PTR_STEP;
	endtask
	initial begin
		#1ms;
		failures++;
		summarize();
	end
	initial begin
		repeat (4) @(negedge clk_i);
		rst_n_i = 1'b1;
		repeat (4) @(negedge clk_i);
		rdchk("mask_rst", REG_MASK, 16'h0000);
		rdchk("cfg_rst", REG_CFG, 16'h0000);
		wr(REG_CFG, 16'hC000);
		rdchk("cfg_illegal", REG_CFG, 16'h0000);
		wr(REG_CFG, 16'hA005);
		rdchk("cfg", REG_CFG, 16'hA005);
		chk("mode_rt", 16'(MODE_RT), 16'(mode));
		chk("area_b", 16'h0001, {15'h0, area_b});
		chk("flags", 16'h000A, {12'h0, flags});
		wr(REG_MASK, 16'h0001);
		ev = '0;
		ev.bus_b = 1'b1;
		msg(ev, 16'hA000, 1, cmdw, 1'b1);
		chk("lut", 16'h0210, lut);
		ev = '0;
		ev.par_err = 1'b1;
		msg(ev, 16'h9400, 1, cmdw, 1'b0);
		ev = '0;
		// a full lap of the stack must land back on the same high byte
		repeat (STACK_ENTRIES) msg(ev, 16'h8000, 1, cmdw, 1'b0);
		wr(REG_CFG, 16'h0010);
		wr(REG_MASK, 16'h0002);
		wr(REG_CMD, 16'h0001);
		chk("run", 16'h0001, {15'h0, run});
		msg(ev, 16'h8000, 0, blka, 1'b0);
		ev.stat_flag = 1'b1;
		msg(ev, 16'h9800, 1, blka, 1'b0);
		chk("stop_err", 16'h0000, {15'h0, run});
		ev = '0;
		ev.no_resp = 1'b1;
		msg(ev, 16'h9200, 1, blka, 1'b0);
		ev = '0;
		ev.loop_fail = 1'b1;
		msg(ev, 16'h9100, 1, blka, 1'b0);
		wr(REG_MASK, 16'h0004);
		wr(REG_CMD, 16'h0001);
		ev = '0;
		ev.block_end = 1'b1;
		msg(ev, 16'h8000, 1, blka, 1'b0);
		u_host.access(1'b0, 3'h4, 16'h0000, rd, oe, ld);
		chk("ext_oe", 16'h0001, 16'(oe));
		u_host.access(1'b1, 3'h5, 16'h5A5A, rd, oe, ld);
		chk("ext_ld", 16'h0001, 16'(ld));
		wr(REG_CMD, 16'h0002);
		rdchk("mask_soft", REG_MASK, 16'h0000);
		rdchk("cfg_soft", REG_CFG, 16'h0000);
		summarize();
	end
endmodule // test_bus_terminal_host_control
